// ---- shared/rtc_pin_pkg.sv ----
/*
 * Constants for the real-time clock output pin selector: register offsets,
 * control field positions, source select codes, status bits and reset values.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package rtc_pin_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS   = 8'h08;
    localparam logic [7:0] PINS_OFS   = 8'h0C;

    // control register fields
    localparam int SEC_SEL_LSB   = 0;
    localparam int SEC_SEL_W     = 3;
    localparam int SEC_LEVEL_BIT = 3;
    localparam int PRI_LEVEL_BIT = 4;
    localparam int CLK_SEL_BIT   = 5;
    localparam int SQW_EN_BIT    = 6;
    localparam int PWR_EN_BIT    = 7;
    localparam int RST_POL_BIT   = 8;
    localparam int EXT_RST_BIT   = 9;
    localparam int CTRL_W        = 10;

    // secondary pin source select codes
    localparam logic [2:0] SEC_SEL_STATIC  = 3'h0;
    localparam logic [2:0] SEC_SEL_SQW     = 3'h1;
    localparam logic [2:0] SEC_SEL_IRQ_N   = 3'h2;
    localparam logic [2:0] SEC_SEL_ALARM_N = 3'h3;
    localparam logic [2:0] SEC_SEL_TIMER   = 3'h4;
    localparam logic [2:0] SEC_SEL_TIMER_N = 3'h5;
    localparam logic [2:0] SEC_SEL_PSW     = 3'h6;

    // status and mask bits
    localparam int EV_IRQ_BIT   = 0;
    localparam int EV_ALARM_BIT = 1;
    localparam int EV_TIMER_BIT = 2;
    localparam int EV_EXT_BIT   = 3;
    localparam int EV_W         = 4;

    // pin readback width
    localparam int PINS_W = 5;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [EV_W-1:0]   MASK_RST = 4'h0;

endpackage : rtc_pin_pkg

// ---- hw/rtc_output_pin_select.sv ----
/*
 * Output pin selector of a real-time clock: routes static levels, square
 * wave, interrupts and power switch control onto the secondary interrupt,
 * timer interrupt, clock output and reset output pins; sets reset polarity.
 * Assumes all source signals are on clk; only the external reset input is
 * a raw pin. Open-drain pins leave the wire level to the pad or bench.
 */
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: static level choice puts the secondary static level bit on the secondary pin.
// RULE2: square wave choice drives square wave on secondary pin when its enable is set.
// RULE3: combined interrupt choice drives its inverse, low while any interrupt pends.
// RULE4: alarm choice drives the inverse of the alarm interrupt on the secondary pin.
// RULE5: timer interrupt may reach the secondary pin true or inverted, per select code.
// RULE6: secondary pin may act as the power switch control output for sleep logic.
// RULE7: with power switch enable set, the secondary pin is a low-impedance switch.
// RULE8: timer interrupt pin always shows the active-low timer interrupt.
// RULE9: static level choice puts the primary static level bit on the clock pin.
// RULE10: clock pin carries square wave when chosen and enabled; it drives both levels.
// RULE11: secondary, timer and reset pins only pull low or release, never drive high.
// RULE12: reset polarity bit sets the active level of the reset output pin.
// RULE13: reset polarity clears to zero at reset, so reset output starts active low.
// RULE14: external reset low with its enable set asserts the reset output.
// RULE15: select fields are registered; a change takes effect the cycle after writing.
module rtc_output_pin_select (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // internal sources
    input  wire logic        square_wave,
    input  wire logic        combined_irq,
    input  wire logic        alarm_interrupt,
    input  wire logic        timer_interrupt,
    input  wire logic        power_switch_ctrl,
    input  wire logic        reset_request,
    // external reset pin, active low
    input  wire logic        external_reset_input_b,
    // secondary interrupt pin
    output logic             secondary_irq_pin_o,
    output logic             secondary_irq_pin_oe,
    output logic             secondary_pin_switch_mode,
    // timer interrupt pin
    output logic             timer_irq_pin_low_o,
    output logic             timer_irq_pin_low_oe,
    // clock output pin, push-pull
    output logic             clock_output_pin,
    // reset output pin
    output logic             reset_output_pin_o,
    output logic             reset_output_pin_oe,
    // interrupt
    output logic             irq
);

    logic [rtc_pin_pkg::CTRL_W-1:0] ctrl_q;
    logic [rtc_pin_pkg::EV_W-1:0]   status_q;
    logic [rtc_pin_pkg::EV_W-1:0]   mask_q;
    logic [rtc_pin_pkg::EV_W-1:0]   ev_prev_q;
    logic [rtc_pin_pkg::EV_W-1:0]   ev_now;
    logic [rtc_pin_pkg::EV_W-1:0]   ev_set;
    logic [rtc_pin_pkg::EV_W-1:0]   ev_clr;
    logic [2:0]                     sec_sel;
    logic                           sec_static;
    logic                           pri_static;
    logic                           clk_sel;
    logic                           sqw_en;
    logic                           pwr_en;
    logic                           rst_pol;
    logic                           ext_rst_en;
    logic                           ext_meta_q;
    logic                           ext_low_q;
    logic                           req;
    logic                           wr_en;
    logic                           sec_level_d;
    logic                           clk_level_d;
    logic                           rst_assert_d;
    logic                           rst_level_d;
    logic [31:0]                    rd_d;

    assign sec_sel    = ctrl_q[rtc_pin_pkg::SEC_SEL_LSB +: rtc_pin_pkg::SEC_SEL_W];
    assign sec_static = ctrl_q[rtc_pin_pkg::SEC_LEVEL_BIT];
    assign pri_static = ctrl_q[rtc_pin_pkg::PRI_LEVEL_BIT];
    assign clk_sel    = ctrl_q[rtc_pin_pkg::CLK_SEL_BIT];
    assign sqw_en     = ctrl_q[rtc_pin_pkg::SQW_EN_BIT];
    assign pwr_en     = ctrl_q[rtc_pin_pkg::PWR_EN_BIT];
    assign rst_pol    = ctrl_q[rtc_pin_pkg::RST_POL_BIT];
    assign ext_rst_en = ctrl_q[rtc_pin_pkg::EXT_RST_BIT];

    // external reset pin synchroniser
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ext_meta_q <= 1'b0;
            ext_low_q  <= 1'b0;
        end else begin
            ext_meta_q <= ~external_reset_input_b;
            ext_low_q  <= ext_meta_q;
        end
    end

    // bus handshake: ack follows the request by one edge, write lands on the ack edge
    assign req   = wb_cyc_i & wb_stb_i;
    assign wr_en = req & wb_we_i & wb_ack_o;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    // control register, bytes 0 and 1
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_q <= rtc_pin_pkg::CTRL_RST; // [RULE13]
        end else if (wr_en && wb_adr_i == rtc_pin_pkg::CTRL_OFS) begin
            if (wb_sel_i[0]) begin
                ctrl_q[7:0] <= wb_dat_i[7:0]; // [RULE15]
            end
            if (wb_sel_i[1]) begin
                ctrl_q[9:8] <= wb_dat_i[9:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mask_q <= rtc_pin_pkg::MASK_RST;
        end else if (wr_en && wb_sel_i[0] && wb_adr_i == rtc_pin_pkg::MASK_OFS) begin
            mask_q <= wb_dat_i[rtc_pin_pkg::EV_W-1:0];
        end
    end

    // events: rising edges of the sources; a set in the clear cycle wins
    assign ev_now = {ext_low_q & ext_rst_en, timer_interrupt, alarm_interrupt, combined_irq};
    assign ev_set = ev_now & ~ev_prev_q;
    assign ev_clr = (wr_en && wb_sel_i[0] && wb_adr_i == rtc_pin_pkg::STATUS_OFS)
                  ? wb_dat_i[rtc_pin_pkg::EV_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ev_prev_q <= '0;
            status_q  <= '0;
        end else begin
            ev_prev_q <= ev_now;
            status_q  <= (status_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (wb_adr_i)
            rtc_pin_pkg::CTRL_OFS:   rd_d[rtc_pin_pkg::CTRL_W-1:0] = ctrl_q;
            rtc_pin_pkg::STATUS_OFS: rd_d[rtc_pin_pkg::EV_W-1:0]   = status_q;
            rtc_pin_pkg::MASK_OFS:   rd_d[rtc_pin_pkg::EV_W-1:0]   = mask_q;
            rtc_pin_pkg::PINS_OFS:   rd_d[rtc_pin_pkg::PINS_W-1:0] = {ext_low_q,
                                         ~reset_output_pin_oe, clock_output_pin,
                                         ~timer_irq_pin_low_oe, ~secondary_irq_pin_oe};
            default:                 rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_ack_o) begin
            wb_dat_o <= rd_d;
        end
    end

    // secondary pin source mux; disabled square wave falls back to the static bit
    always_comb begin
        unique case (sec_sel)
            rtc_pin_pkg::SEC_SEL_STATIC:  sec_level_d = sec_static;                  // [RULE1]
            rtc_pin_pkg::SEC_SEL_SQW:     sec_level_d = sqw_en ? square_wave
                                                               : sec_static;        // [RULE2]
            rtc_pin_pkg::SEC_SEL_IRQ_N:   sec_level_d = ~combined_irq;               // [RULE3]
            rtc_pin_pkg::SEC_SEL_ALARM_N: sec_level_d = ~alarm_interrupt;            // [RULE4]
            rtc_pin_pkg::SEC_SEL_TIMER:   sec_level_d = timer_interrupt;             // [RULE5]
            rtc_pin_pkg::SEC_SEL_TIMER_N: sec_level_d = ~timer_interrupt;            // [RULE5]
            rtc_pin_pkg::SEC_SEL_PSW:     sec_level_d = ~power_switch_ctrl;          // [RULE6]
            default:                      sec_level_d = sec_static;
        endcase
    end

    always_comb begin
        clk_level_d = (clk_sel && sqw_en) ? square_wave : pri_static; // [RULE9] [RULE10]
    end

    // reset output: asserted from the request or the enabled external pin
    always_comb begin
        rst_assert_d = reset_request | (ext_low_q & ext_rst_en);     // [RULE14]
        rst_level_d  = rst_assert_d ? rst_pol : ~rst_pol;            // [RULE12]
    end

    // open-drain pins hold their data at zero and only toggle the enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            secondary_irq_pin_o       <= 1'b0;
            secondary_irq_pin_oe      <= 1'b0;
            secondary_pin_switch_mode <= 1'b0;
        end else begin
            secondary_irq_pin_o       <= 1'b0;                       // [RULE11]
            secondary_irq_pin_oe      <= ~sec_level_d;               // [RULE15]
            secondary_pin_switch_mode <= pwr_en;                     // [RULE7]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timer_irq_pin_low_o  <= 1'b0;
            timer_irq_pin_low_oe <= 1'b0;
        end else begin
            timer_irq_pin_low_o  <= 1'b0;                            // [RULE11]
            timer_irq_pin_low_oe <= timer_interrupt;                 // [RULE8]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clock_output_pin <= 1'b0;
        end else begin
            clock_output_pin <= clk_level_d;                         // [RULE10]
        end
    end

    // released during reset; polarity is not known to the pad until set
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reset_output_pin_o  <= 1'b0;
            reset_output_pin_oe <= 1'b0;
        end else begin
            reset_output_pin_o  <= 1'b0;                             // [RULE11]
            reset_output_pin_oe <= ~rst_level_d;                     // [RULE12]
        end
    end

    property p_sec_static;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && sec_sel == rtc_pin_pkg::SEC_SEL_STATIC)
            |=> secondary_irq_pin_oe == !$past(sec_static);
    endproperty
    a_sec_static: assert property (p_sec_static) // [RULE1]
        else $error("secondary pin does not follow static level bit");

    property p_sec_sqw;
        @(posedge clk) disable iff (!rst_b)
        (sec_sel == rtc_pin_pkg::SEC_SEL_SQW && sqw_en)
            |=> secondary_irq_pin_oe == !$past(square_wave);
    endproperty
    a_sec_sqw: assert property (p_sec_sqw) // [RULE2]
        else $error("secondary pin does not carry square wave");

    property p_sec_irq;
        @(posedge clk) disable iff (!rst_b)
        (sec_sel == rtc_pin_pkg::SEC_SEL_IRQ_N && combined_irq) |=> secondary_irq_pin_oe;
    endproperty
    a_sec_irq: assert property (p_sec_irq) // [RULE3]
        else $error("secondary pin not low while combined interrupt pends");

    property p_sec_alarm;
        @(posedge clk) disable iff (!rst_b)
        sec_sel == rtc_pin_pkg::SEC_SEL_ALARM_N
            |=> secondary_irq_pin_oe == $past(alarm_interrupt);
    endproperty
    a_sec_alarm: assert property (p_sec_alarm) // [RULE4]
        else $error("secondary pin not the inverse of alarm interrupt");

    property p_sec_timer;
        @(posedge clk) disable iff (!rst_b)
        (sec_sel == rtc_pin_pkg::SEC_SEL_TIMER || sec_sel == rtc_pin_pkg::SEC_SEL_TIMER_N)
            |=> secondary_irq_pin_oe
                == ($past(timer_interrupt) ^ ($past(sec_sel) == rtc_pin_pkg::SEC_SEL_TIMER));
    endproperty
    a_sec_timer: assert property (p_sec_timer) // [RULE5]
        else $error("secondary pin has wrong timer interrupt sense");

    property p_sec_psw;
        @(posedge clk) disable iff (!rst_b)
        sec_sel == rtc_pin_pkg::SEC_SEL_PSW |=> secondary_irq_pin_oe == $past(power_switch_ctrl);
    endproperty
    a_sec_psw: assert property (p_sec_psw) // [RULE6]
        else $error("secondary pin does not follow power switch control");

    property p_switch_mode;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> secondary_pin_switch_mode == $past(pwr_en);
    endproperty
    a_switch_mode: assert property (p_switch_mode) // [RULE7]
        else $error("switch mode does not follow power switch enable");

    property p_timer_pin;
        @(posedge clk) disable iff (!rst_b)
        timer_interrupt |=> timer_irq_pin_low_oe;
    endproperty
    a_timer_pin: assert property (p_timer_pin) // [RULE8]
        else $error("timer pin not pulled low on timer interrupt");

    property p_clk_static;
        @(posedge clk) disable iff (!rst_b)
        !clk_sel |=> clock_output_pin == $past(pri_static);
    endproperty
    a_clk_static: assert property (p_clk_static) // [RULE9]
        else $error("clock pin does not follow primary static level");

    property p_clk_sqw;
        @(posedge clk) disable iff (!rst_b)
        (clk_sel && sqw_en) |=> clock_output_pin == $past(square_wave);
    endproperty
    a_clk_sqw: assert property (p_clk_sqw) // [RULE10]
        else $error("clock pin does not carry square wave");

    property p_open_drain;
        @(posedge clk) disable iff (!rst_b)
        !secondary_irq_pin_o && !timer_irq_pin_low_o && !reset_output_pin_o;
    endproperty
    a_open_drain: assert property (p_open_drain) // [RULE11]
        else $error("open-drain pin driven high");

    property p_rst_pol;
        @(posedge clk) disable iff (!rst_b)
        reset_request |=> reset_output_pin_oe == !$past(rst_pol);
    endproperty
    a_rst_pol: assert property (p_rst_pol) // [RULE12]
        else $error("reset output asserted at wrong level");

    property p_pol_reset;
        @(posedge clk) disable iff (!rst_b)
        !$past(rst_b) |-> !rst_pol;
    endproperty
    a_pol_reset: assert property (p_pol_reset) // [RULE13]
        else $error("reset polarity not cleared by reset");

    property p_ext_rst;
        @(posedge clk) disable iff (!rst_b)
        (!external_reset_input_b && ext_rst_en && !rst_pol) [*3] |=> reset_output_pin_oe;
    endproperty
    a_ext_rst: assert property (p_ext_rst) // [RULE14]
        else $error("external reset does not assert reset output");

    property p_sel_write;
        @(posedge clk) disable iff (!rst_b)
        (wr_en && wb_sel_i[0] && wb_adr_i == rtc_pin_pkg::CTRL_OFS)
            |=> sec_sel == $past(wb_dat_i[2:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) // [RULE15]
        else $error("select field not updated by write");

endmodule : rtc_output_pin_select

// ---- bench/rtc_pin_pad_model.sv ----
/*
 * Pad and board model for the pin selector: external pull-ups on the
 * open-drain pins, giving the wire level that the host sees.
 * Assumes oe high means the pin is pulled to its output value.
 */
`timescale 1ns/1ps

module rtc_pin_pad_model (
    // open-drain drive from the selector
    input  wire logic sec_o,
    input  wire logic sec_oe,
    input  wire logic tmr_o,
    input  wire logic tmr_oe,
    input  wire logic rst_o,
    input  wire logic rst_oe,
    // wire levels seen by the host
    output logic      sec_lvl,
    output logic      tmr_lvl,
    output logic      rst_lvl
);
    // released pins float up, never keep the last driven value
    assign sec_lvl = sec_oe ? sec_o : 1'b1;
    assign tmr_lvl = tmr_oe ? tmr_o : 1'b1;
    assign rst_lvl = rst_oe ? rst_o : 1'b1;
endmodule : rtc_pin_pad_model

// ---- bench/rtc_output_pin_select_tb_top.sv ----
/*
 * Self-checking bench for the output pin selector: register access over
 * classic Wishbone, source routing to every pin, reset output, interrupt.
 * Assumes the pad model supplies pull-ups on the open-drain pins.
 */
`timescale 1ns/1ps

module rtc_output_pin_select_tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_word;
    logic        wb_ack_o, irq, clock_output_pin, sw_mode;
    logic        square_wave = 1'b0, combined_irq = 1'b0, alarm_interrupt = 1'b0;
    logic        timer_interrupt = 1'b0, power_switch_ctrl = 1'b0, reset_request = 1'b0;
    logic        ext_rst_b = 1'b1;
    logic        sec_o, sec_oe, tmr_o, tmr_oe, rst_o, rst_oe, sec_lvl, tmr_lvl, rst_lvl;
    int          fail_count = 0;
    int          n_tests = 0;

    always #50 clk = ~clk;

    rtc_output_pin_select DUT (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .square_wave(square_wave), .combined_irq(combined_irq),
        .alarm_interrupt(alarm_interrupt), .timer_interrupt(timer_interrupt),
        .power_switch_ctrl(power_switch_ctrl), .reset_request(reset_request),
        .external_reset_input_b(ext_rst_b), .secondary_irq_pin_o(sec_o),
        .secondary_irq_pin_oe(sec_oe), .secondary_pin_switch_mode(sw_mode),
        .timer_irq_pin_low_o(tmr_o), .timer_irq_pin_low_oe(tmr_oe),
        .clock_output_pin(clock_output_pin), .reset_output_pin_o(rst_o),
        .reset_output_pin_oe(rst_oe), .irq(irq));

    rtc_pin_pad_model pads (.sec_o(sec_o), .sec_oe(sec_oe), .tmr_o(tmr_o), .tmr_oe(tmr_oe),
        .rst_o(rst_o), .rst_oe(rst_oe), .sec_lvl(sec_lvl), .tmr_lvl(tmr_lvl),
        .rst_lvl(rst_lvl));

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    // holds the request until ack is sampled, then idles one cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk_bit("wb_ack_wait", 1'b1, n == 2);
        rd_word = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic src(input logic v);
        square_wave       <= v;
        combined_irq      <= v;
        alarm_interrupt   <= v;
        timer_interrupt   <= v;
        power_switch_ctrl <= v;
        repeat (4) @(posedge clk);
    endtask : src

    task automatic t_reset_values;
        wb(1'b0, rtc_pin_pkg::CTRL_OFS, 32'h0);
        chk_word("ctrl", 32'h0000_0000, rd_word);
        wb(1'b0, rtc_pin_pkg::MASK_OFS, 32'h0);
        chk_word("mask", 32'h0000_0000, rd_word);
        wb(1'b0, 8'h40, 32'h0);
        chk_word("unmapped", 32'h0000_0000, rd_word);
        reset_request <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bit("rst_lvl", 1'b0, rst_lvl);
        reset_request <= 1'b0;
    endtask : t_reset_values

    // every select code, both source levels, square wave enable on and off
    task automatic t_routing;
        logic [2:0] code;
        logic       e;
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < 4; s++) begin
                code = c[2:0];
                wb(1'b1, rtc_pin_pkg::CTRL_OFS, {22'h0, 1'b0, 1'b0, code == 3'h6, s[1],
                   code[0], ~s[0], ~s[0], code});
                src(s[0]);
                case (code)
                    3'h1:       e = s[1] ? s[0] : ~s[0];
                    3'h2, 3'h3: e = ~s[0];
                    3'h4:       e = s[0];
                    3'h5, 3'h6: e = ~s[0];
                    default:    e = ~s[0];
                endcase
                chk_bit("sec_lvl", e, sec_lvl);
                chk_bit("sw_mode", code == 3'h6, sw_mode);
                chk_bit("sec_o", 1'b0, sec_o);
                chk_bit("tmr_lvl", ~s[0], tmr_lvl);
                chk_bit("clkout", (code[0] && s[1]) ? s[0] : ~s[0], clock_output_pin);
            end
        end
        // sources back to idle so later edge-triggered events can rise
        src(1'b0);
    endtask : t_routing

    task automatic t_reset_out;
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, rtc_pin_pkg::CTRL_OFS, {22'h0, i[2], i[0], 8'h00});
            reset_request <= i[1] && !i[2];
            ext_rst_b     <= !(i[1] && i[2]);
            repeat (5) @(posedge clk);
            chk_bit("rst_lvl", i[1] ? i[0] : ~i[0], rst_lvl);
            chk_bit("rst_o", 1'b0, rst_o);
        end
        ext_rst_b     <= 1'b1;
        reset_request <= 1'b0;
    endtask : t_reset_out

    task automatic t_select_timing;
        wb(1'b1, rtc_pin_pkg::CTRL_OFS, 32'h0000_0000);
        repeat (2) @(posedge clk);
        wb(1'b1, rtc_pin_pkg::CTRL_OFS, 32'h0000_0008);
        @(negedge clk);
        chk_bit("sec_lvl_next", 1'b1, sec_lvl);
        @(posedge clk);
        wb(1'b0, rtc_pin_pkg::PINS_OFS, 32'h0);
        chk_word("pins", 32'h0000_000B, rd_word);
    endtask : t_select_timing

    task automatic t_irq;
        wb(1'b1, rtc_pin_pkg::STATUS_OFS, 32'h0000_000F);
        wb(1'b1, rtc_pin_pkg::MASK_OFS, 32'h0000_0002);
        wb(1'b0, rtc_pin_pkg::MASK_OFS, 32'h0);
        chk_word("mask", 32'h0000_0002, rd_word);
        alarm_interrupt <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bit("irq", 1'b1, irq);
        alarm_interrupt <= 1'b0;
        wb(1'b1, rtc_pin_pkg::STATUS_OFS, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk_bit("irq_cleared", 1'b0, irq);
        wb(1'b1, rtc_pin_pkg::MASK_OFS, 32'h0000_0000);
        alarm_interrupt <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bit("irq_masked", 1'b0, irq);
        wb(1'b0, rtc_pin_pkg::STATUS_OFS, 32'h0);
        chk_word("status", 32'h0000_0002, rd_word & 32'h0000_0002);
        alarm_interrupt <= 1'b0;
    endtask : t_irq

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_routing();
        t_reset_out();
        t_select_timing();
        t_irq();
        results();
    end

    // whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule : rtc_output_pin_select_tb_top
